// ---- logic/byte_alu_pkg.sv ----
// Behaviour
// RULE1 - subtract_work_from_file yields the file operand minus the working register in 8-bit two's complement.
// RULE2 - subtract_work_from_file updates carry, half_carry_flag and zero from its result and nothing else.
// RULE3 - xor_work_with_file yields working register XOR file operand and updates only the zero flag.
// RULE4 - destination select 1 writes the result to the addressed file register, 0 to the working register.
// RULE5 - swap_file_nibbles moves source bits 3..0 to result bits 7..4 and bits 7..4 to bits 3..0.
// RULE6 - swap_file_nibbles leaves every status flag unchanged.
// RULE7 - swap_file_nibbles with destination 0 loads the working register and leaves the file register alone.
// RULE8 - the file operand is chosen by a 7-bit address covering 0 to 127 in the current bank.
`default_nettype none
package byte_alu_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic WRITE_RESET = 1'b0;
  localparam logic [6:0] FILE_ADDR_RESET = 7'h00;
  localparam logic [7:0] FILE_DATA_RESET = 8'h00;
  // flag positions within the status triple
  localparam int CARRY_BIT = 0;
  localparam int HALF_BIT = 1;
  localparam int ZERO_BIT = 2;
  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_SUB = 2'b01,
    OP_XOR = 2'b10,
    OP_SWAP = 2'b11
  } alu_op_t;
endpackage
`default_nettype wire

// ---- logic/byte_alu_subtract_xor_swap.sv ----
`timescale 1ns/1ps
`default_nettype none
module byte_alu_subtract_xor_swap (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // instruction from decoder
  input wire logic opValid,
  input wire byte_alu_pkg::alu_op_t opCode,
  input wire logic destSel,
  input wire logic [6:0] fileAddr,
  // operand read from file array
  input wire logic [7:0] fileData,
  // write back to file array
  output logic fileWrite,
  output logic [6:0] fileWriteAddr,
  output logic [7:0] fileWriteData,
  // working register and status
  output logic [7:0] workReg,
  output logic carryFlag,
  output logic halfCarryFlag,
  output logic zeroFlag
);
  // ==========================================
  // state
  typedef struct packed {
    logic fileWrite;
    logic [6:0] fileWriteAddr;
    logic [7:0] fileWriteData;
    logic [7:0] workReg;
    logic [2:0] flags;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic [8:0] diff;
  logic [4:0] lowDiff;
  logic [7:0] result;
  logic opTaken;

  // ==========================================
  // helpers
  // subtract as add of complement plus one; top bit is the no-borrow carry
  function automatic logic [8:0] sub_byte(input logic [7:0] minuend, input logic [7:0] subtrahend);
    sub_byte = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
  endfunction

  // same scheme on the low nibble, which gives the half carry
  function automatic logic [4:0] sub_nibble(input logic [3:0] minuend, input logic [3:0] subtrahend);
    sub_nibble = {1'b0, minuend} + {1'b0, ~subtrahend} + 5'h01;
  endfunction

  // zero test shared by subtract and xor
  function automatic logic is_zero(input logic [7:0] value);
    is_zero = (value == 8'h00);
  endfunction

  // nibble exchange of one byte
  function automatic logic [7:0] swap_halves(input logic [7:0] value);
    swap_halves = {value[3:0], value[7:4]};
  endfunction

  // ==========================================
  // datapath
  always_comb begin
    next_cur = cur; // RULE6
    next_cur.fileWrite = 1'b0; // strobe, never held
    opTaken = opValid && (opCode != byte_alu_pkg::OP_NONE);
    diff = sub_byte(fileData, cur.workReg); // RULE1
    lowDiff = sub_nibble(fileData[3:0], cur.workReg[3:0]);
    result = 8'h00;
    unique case (opCode)
      byte_alu_pkg::OP_SUB: result = diff[7:0]; // RULE1
      byte_alu_pkg::OP_XOR: result = cur.workReg ^ fileData; // RULE3
      byte_alu_pkg::OP_SWAP: result = swap_halves(fileData); // RULE5
      byte_alu_pkg::OP_NONE: result = 8'h00;
    endcase
    if (opTaken) begin
      // borrow is carry low, as in any add-of-complement subtractor
      if (destSel == byte_alu_pkg::DEST_FILE) begin // RULE4
        next_cur.fileWrite = 1'b1;
        next_cur.fileWriteAddr = fileAddr; // RULE8
        next_cur.fileWriteData = result;
      end else begin
        next_cur.workReg = result; // RULE7
      end
      if (opCode == byte_alu_pkg::OP_SUB) begin
        next_cur.flags[byte_alu_pkg::CARRY_BIT] = diff[8]; // RULE2
        next_cur.flags[byte_alu_pkg::HALF_BIT] = lowDiff[4]; // RULE2
        next_cur.flags[byte_alu_pkg::ZERO_BIT] = is_zero(result);
      end else if (opCode == byte_alu_pkg::OP_XOR) begin
        next_cur.flags[byte_alu_pkg::ZERO_BIT] = is_zero(result); // RULE3
      end
      // swap touches no flag at all
    end
  end

  // ==========================================
  // registers
  // async clear so the core starts from a known working register and flags
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur.fileWrite <= byte_alu_pkg::WRITE_RESET;
      cur.fileWriteAddr <= byte_alu_pkg::FILE_ADDR_RESET;
      cur.fileWriteData <= byte_alu_pkg::FILE_DATA_RESET;
      cur.workReg <= byte_alu_pkg::WORK_RESET;
      cur.flags <= byte_alu_pkg::FLAGS_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // output taps, all straight from the state register
  assign fileWrite = cur.fileWrite;
  assign fileWriteAddr = cur.fileWriteAddr;
  assign fileWriteData = cur.fileWriteData;
  assign workReg = cur.workReg;
  assign carryFlag = cur.flags[byte_alu_pkg::CARRY_BIT];
  assign halfCarryFlag = cur.flags[byte_alu_pkg::HALF_BIT];
  assign zeroFlag = cur.flags[byte_alu_pkg::ZERO_BIT];

  // ==========================================
  // checks
  // all sample on the core clock and sleep through reset

  // subtract into the working register
  chk_sub_value: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE1
    opValid && opCode == byte_alu_pkg::OP_SUB && !destSel |=> workReg == 8'($past(fileData) - $past(workReg)))
    else $error("subtract result wrong");

  // zero after subtract means equal operands
  chk_sub_zero: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE2
    opValid && opCode == byte_alu_pkg::OP_SUB |=> zeroFlag == ($past(fileData) == $past(workReg)))
    else $error("subtract zero flag wrong");

  // carry set means no borrow
  chk_sub_carry: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE2
    opValid && opCode == byte_alu_pkg::OP_SUB |=> carryFlag == ($past(fileData) >= $past(workReg)))
    else $error("subtract carry wrong");

  // xor moves only the zero flag
  chk_xor_flags: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE3
    opValid && opCode == byte_alu_pkg::OP_XOR |=> $stable(carryFlag) && $stable(halfCarryFlag)
      && zeroFlag == ($past(fileData) == $past(workReg)))
    else $error("xor flags wrong");

  // file destination writes back and spares the working register
  chk_dest_file: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE4
    opValid && opCode != byte_alu_pkg::OP_NONE && destSel |=> fileWrite && $stable(workReg)
      && fileWriteAddr == $past(fileAddr))
    else $error("file destination not honoured");

  // swapped byte written back
  chk_swap_value: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE5
    opValid && opCode == byte_alu_pkg::OP_SWAP && destSel |=>
      fileWriteData == {$past(fileData[3:0]), $past(fileData[7:4])})
    else $error("swap data wrong");

  // swap is flag neutral
  chk_swap_flags: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE6
    opValid && opCode == byte_alu_pkg::OP_SWAP |=> $stable(carryFlag) && $stable(halfCarryFlag) && $stable(zeroFlag))
    else $error("swap altered a flag");

  // swap into the working register leaves the file alone
  chk_swap_work: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE7
    opValid && opCode == byte_alu_pkg::OP_SWAP && !destSel |=>
      !fileWrite && workReg == {$past(fileData[3:0]), $past(fileData[7:4])})
    else $error("swap to work wrong");

  // half carry set means no borrow out of the low nibble
  chk_sub_half: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE2
    opValid && opCode == byte_alu_pkg::OP_SUB |=> halfCarryFlag == ($past(fileData[3:0]) >= $past(workReg[3:0])))
    else $error("subtract half carry wrong");

  // subtract written back to the file
  chk_sub_file: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE1
    opValid && opCode == byte_alu_pkg::OP_SUB && destSel |=> fileWriteData == 8'($past(fileData) - $past(workReg)))
    else $error("subtract file data wrong");

  // subtract to work issues no write
  chk_sub_no_write: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE4
    opValid && opCode == byte_alu_pkg::OP_SUB && !destSel |=> !fileWrite && $stable(fileWriteData))
    else $error("subtract wrote the file");

  // xor into the working register
  chk_xor_value: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE3
    opValid && opCode == byte_alu_pkg::OP_XOR && !destSel |=> workReg == ($past(workReg) ^ $past(fileData)))
    else $error("xor result wrong");

  // xor written back to the file
  chk_xor_file: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE3
    opValid && opCode == byte_alu_pkg::OP_XOR && destSel |=> fileWriteData == ($past(workReg) ^ $past(fileData)))
    else $error("xor file data wrong");

  // work destination never strobes the file
  chk_dest_work: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE4
    opValid && opCode != byte_alu_pkg::OP_NONE && !destSel |=> !fileWrite)
    else $error("work destination wrote the file");

  // refused cycles change nothing visible
  chk_idle_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE4
    !(opValid && opCode != byte_alu_pkg::OP_NONE) |=> !fileWrite && $stable(workReg))
    else $error("idle cycle changed state");

  // refused cycles keep every flag
  chk_idle_flags: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE2
    !(opValid && opCode != byte_alu_pkg::OP_NONE) |=> $stable(carryFlag) && $stable(halfCarryFlag) && $stable(zeroFlag))
    else $error("idle cycle changed a flag");

  // swap to work leaves the write port as it was
  chk_swap_keep: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE7
    opValid && opCode == byte_alu_pkg::OP_SWAP && !destSel |=> $stable(fileWriteData) && $stable(fileWriteAddr))
    else $error("swap to work touched write port");

  // swap back to the file uses the given address
  chk_swap_addr: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE8
    opValid && opCode == byte_alu_pkg::OP_SWAP && destSel |=> fileWrite && fileWriteAddr == $past(fileAddr))
    else $error("swap address wrong");

  // a write strobe only follows a taken file-destination op
  chk_write_cause: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE4
    fileWrite |-> $past(opValid) && $past(destSel) && $past(opCode) != byte_alu_pkg::OP_NONE)
    else $error("write strobe without cause");
endmodule
`default_nettype wire

// ---- verif/file_array_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module file_array_model (
  // clock
  input wire logic ref_clk,
  // operand lookup
  input wire logic [6:0] fileAddr,
  output logic [7:0] fileData,
  // write back
  input wire logic fileWrite,
  input wire logic [6:0] fileWriteAddr,
  input wire logic [7:0] fileWriteData
);
  // =====
  // file array
  logic [7:0] mem [128];
  // read is combinational, so the operand is there in the request cycle
  assign fileData = mem[fileAddr];
  // a write lands one edge after the pulse, so a read of it must wait
  always @(posedge ref_clk) begin
    if (fileWrite) mem[fileWriteAddr] <= fileWriteData;
  end
endmodule
`default_nettype wire

// ---- verif/byte_alu_subtract_xor_swap_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module byte_alu_subtract_xor_swap_tb;
  // =====
  // bench
  logic ref_clk = 0, reset_n = 0, opValid = 0, destSel = 0, fileWrite, carryFlag, halfCarryFlag, zeroFlag;
  byte_alu_pkg::alu_op_t opCode = byte_alu_pkg::OP_NONE;
  logic [6:0] fileAddr = 7'h00, fileWriteAddr;
  logic [7:0] fileData, fileWriteData, workReg, w = 8'h00, r;
  logic [2:0] fl = 3'h0;
  int bad_count = 0, checks_done = 0, cyc = 0;
  byte_alu_subtract_xor_swap i_dut (.ref_clk, .reset_n, .opValid, .opCode, .destSel, .fileAddr, .fileData,
    .fileWrite, .fileWriteAddr, .fileWriteData, .workReg, .carryFlag, .halfCarryFlag, .zeroFlag);
  file_array_model i_mem (.ref_clk, .fileAddr, .fileData, .fileWrite, .fileWriteAddr, .fileWriteData);
  initial forever #50 ref_clk = ~ref_clk;
  // hang guard, far above the few dozen cycles needed
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 500) begin
      bad_count++;
      give_verdict();
    end
  end
  task give_verdict;
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t %h %h", $time, seen, exp);
    end
  endtask
  task look(input logic d);
    check({4'h0, zeroFlag, halfCarryFlag, carryFlag, fileWrite, workReg}, {4'h0, fl, d, w});
  endtask
  // flags as add-of-complement: set means no borrow
  task run(input byte_alu_pkg::alu_op_t c, input logic d, input logic [6:0] a, input logic [7:0] f);
    i_mem.mem[a] = f;
    @(posedge ref_clk);
    opValid <= 1'b1;
    opCode <= c;
    destSel <= d;
    fileAddr <= a;
    @(posedge ref_clk);
    opValid <= 1'b0;
    case (c)
      byte_alu_pkg::OP_SUB: begin r = f - w; fl = {r == 8'h00, f[3:0] >= w[3:0], f >= w}; end
      byte_alu_pkg::OP_XOR: begin r = f ^ w; fl[2] = r == 8'h00; end
      default: r = {f[3:0], f[7:4]};
    endcase
    if (!d) w = r;
    #1;
    look(d);
    if (d) check({1'b0, fileWriteAddr, fileWriteData}, {1'b0, a, r});
    @(posedge ref_clk);
    #1;
    check({8'h00, i_mem.mem[a]}, {8'h00, d ? r : f});
  endtask
  task t_xor;
    run(byte_alu_pkg::OP_XOR, 1'b0, 7'h01, 8'h03);
    run(byte_alu_pkg::OP_XOR, 1'b1, 7'h7f, 8'h03);
  endtask
  task t_sub;
    run(byte_alu_pkg::OP_SUB, 1'b0, 7'h02, 8'h05);
    run(byte_alu_pkg::OP_SUB, 1'b1, 7'h03, 8'h02);
    run(byte_alu_pkg::OP_SUB, 1'b0, 7'h04, 8'h10);
    run(byte_alu_pkg::OP_SUB, 1'b1, 7'h00, 8'h01);
  endtask
  // zero set first so a swap that touched flags would show
  task t_swap;
    run(byte_alu_pkg::OP_XOR, 1'b1, 7'h10, w);
    run(byte_alu_pkg::OP_SWAP, 1'b0, 7'h05, 8'h5a);
    run(byte_alu_pkg::OP_SWAP, 1'b1, 7'h7f, 8'h0f);
  endtask
  task t_refuse;
    @(posedge ref_clk);
    opValid <= 1'b1;
    opCode <= byte_alu_pkg::OP_NONE;
    destSel <= 1'b1;
    @(posedge ref_clk);
    opValid <= 1'b0;
    opCode <= byte_alu_pkg::OP_SUB;
    repeat (2) @(posedge ref_clk);
    #1;
    look(1'b0);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    look(1'b0);
    t_xor();
    t_sub();
    t_swap();
    t_refuse();
    give_verdict();
  end
endmodule
`default_nettype wire
